// File: design/ses_regs.vh
// Constants for the status event summary block: bit positions, reset
// values and error band codes. Included by the single design file.
// How it works
// - Operation complete sets event bit 0
// - Query error cases set event bit 2
// - Device or positive errors set bit 3
// - Execution errors set event bit 4
// - Command syntax errors set event bit 5
// - Power-on sets bit 7 until read or clear
// - Event bits 1,6 and status bit 0 zero
// - Enabled alarm bits set status bit 1
// - Error queue nonempty sets status bit 2
// - Enabled questionable bits set status bit 3
// - Unread output data sets status bit 4
// - Enabled standard events set status bit 5
// - Enabled status bits raise service request
// - Enabled operation bits set status bit 7
`ifndef SES_REGS_VH
`define SES_REGS_VH

// Standard event latch bit positions
`define SES_EV_OPC      0
`define SES_EV_QUERY    2
`define SES_EV_DEVICE   3
`define SES_EV_EXEC     4
`define SES_EV_CMD      5
`define SES_EV_PWR      7
`define SES_EV_USED     8'hbd
`define SES_EV_RESET    8'h80

// Status summary byte bit positions
`define SES_SB_ALARM    1
`define SES_SB_ERRQ     2
`define SES_SB_QUES     3
`define SES_SB_MAV      4
`define SES_SB_ESB      5
`define SES_SB_RQS      6
`define SES_SB_OPER     7

// Error code ranges (signed hundreds)
`define SES_ERR_CMD     3'h1
`define SES_ERR_EXEC    3'h2
`define SES_ERR_DEV     3'h3

`endif

// File: design/ses_core.v
// Status event summary core: standard event latch, status byte summary,
// service request. Assumes event strobes and register views arrive from
// logic on the same clock; error queue storage is kept here.
`timescale 1ns/100ps
`default_nettype none
`include "ses_regs.vh"

module ses_core #(
  parameter SRC_W   = 16,
  parameter ERRQ_D  = 8,
  parameter ERRQ_AW = 3
) (
  input  wire              clk,
  input  wire              rstn,
  input  wire              opc_done,
  input  wire              rd_empty_out,
  input  wire              line_before_read,
  input  wire              both_bufs_full,
  input  wire              err_valid,
  input  wire signed [15:0] err_code,
  input  wire              err_read,
  input  wire              ev_read,
  input  wire              ev_clear,
  input  wire [7:0]        ev_enable,
  input  wire [7:0]        srq_enable,
  input  wire [SRC_W-1:0]  alarm_bits,
  input  wire [SRC_W-1:0]  alarm_enable,
  input  wire [SRC_W-1:0]  ques_bits,
  input  wire [SRC_W-1:0]  ques_enable,
  input  wire [SRC_W-1:0]  oper_bits,
  input  wire [SRC_W-1:0]  oper_enable,
  input  wire              out_pending,
  output reg  [7:0]        standard_event_latch,
  output reg  [7:0]        ev_read_data,
  output wire [7:0]        status_summary_byte,
  output wire              service_request,
  output reg  signed [15:0] err_read_data,
  output wire              err_queue_full
);

  // =====================================================================
  // Helpers
  function summary;
    input [SRC_W-1:0] bits;
    input [SRC_W-1:0] mask;
    begin
      summary = |(bits & mask);
    end
  endfunction

  // Classify negative code into its hundreds band; 0 when not negative
  function [2:0] err_band;
    input signed [15:0] code;
    reg   signed [15:0] mag;
    begin
      mag = -code;
      if (code >= 16'sd0) begin
        err_band = 3'h0;
      end else if (mag >= 16'sd100 && mag <= 16'sd199) begin
        err_band = `SES_ERR_CMD;
      end else if (mag >= 16'sd200 && mag <= 16'sd299) begin
        err_band = `SES_ERR_EXEC;
      end else if (mag >= 16'sd300 && mag <= 16'sd399) begin
        err_band = `SES_ERR_DEV;
      end else begin
        err_band = 3'h0;
      end
    end
  endfunction

  // =====================================================================
  // Event strobes
  wire [2:0] band = err_band(err_code);
  reg  [7:0] ev_set;

  always @* begin
    ev_set = 8'h00;
    ev_set[`SES_EV_OPC]    = opc_done;
    ev_set[`SES_EV_QUERY]  = rd_empty_out | line_before_read | both_bufs_full;
    ev_set[`SES_EV_DEVICE] = err_valid & ((band == `SES_ERR_DEV) | (err_code > 16'sd0));
    ev_set[`SES_EV_EXEC]   = err_valid & (band == `SES_ERR_EXEC);
    ev_set[`SES_EV_CMD]    = err_valid & (band == `SES_ERR_CMD);
  end

  // =====================================================================
  // Standard event latch
  // Reset value carries the power-on bit; nothing else raises it.
  wire [7:0] next_latch = ((ev_read | ev_clear) ? 8'h00 : standard_event_latch)
                          | (ev_set & `SES_EV_USED);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standard_event_latch <= `SES_EV_RESET;
      ev_read_data         <= 8'h00;
    end else begin
      standard_event_latch <= next_latch;
      if (ev_read) begin
        ev_read_data <= standard_event_latch;
      end
    end
  end

  // =====================================================================
  // Error queue, oldest first
  reg signed [15:0]    errq_mem [0:ERRQ_D-1];
  reg [ERRQ_AW-1:0]    wr_ptr;
  reg [ERRQ_AW-1:0]    rd_ptr;
  reg [ERRQ_AW:0]      errq_count;

  wire errq_empty = (errq_count == {(ERRQ_AW+1){1'b0}});
  assign err_queue_full = (errq_count == ERRQ_D[ERRQ_AW:0]);
  // A full queue drops the newest entry; the event bits still record it.
  wire do_push = err_valid & ~err_queue_full;
  wire do_pop  = err_read & ~errq_empty;

  always @(posedge clk) begin
    if (do_push) begin
      errq_mem[wr_ptr] <= err_code;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr        <= {ERRQ_AW{1'b0}};
      rd_ptr        <= {ERRQ_AW{1'b0}};
      errq_count    <= {(ERRQ_AW+1){1'b0}};
      err_read_data <= 16'sd0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (err_read) begin
        err_read_data <= errq_empty ? 16'sd0 : errq_mem[rd_ptr];
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      case ({do_push, do_pop})
        2'b10:   errq_count <= errq_count + 1'b1;
        2'b01:   errq_count <= errq_count - 1'b1;
        default: errq_count <= errq_count;
      endcase
    end
  end

  // =====================================================================
  // Status summary byte
  wire [7:0] sb_base;
  assign sb_base[0]             = 1'b0;
  assign sb_base[`SES_SB_ALARM] = summary(alarm_bits, alarm_enable);
  assign sb_base[`SES_SB_ERRQ]  = ~errq_empty;
  assign sb_base[`SES_SB_QUES]  = summary(ques_bits, ques_enable);
  assign sb_base[`SES_SB_MAV]   = out_pending;
  assign sb_base[`SES_SB_ESB]   = |(standard_event_latch & ev_enable);
  assign sb_base[`SES_SB_RQS]   = 1'b0;
  assign sb_base[`SES_SB_OPER]  = summary(oper_bits, oper_enable);

  // Own bit excluded from the mask so the request cannot hold itself up
  assign service_request = |(sb_base & srq_enable & 8'hbf);
  assign status_summary_byte = sb_base | {1'b0, service_request, 6'h00};

endmodule
`default_nettype wire

// File: verif/ses_properties.sv
// Checker for the status event summary core, bound to its ports.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module ses_props #(parameter SRC_W = 16) (
  input wire              clk, rstn, opc_done, rd_empty_out, line_before_read,
  input wire              both_bufs_full, err_valid, ev_read, out_pending, service_request,
  input wire signed [15:0] err_code,
  input wire [7:0]        ev_enable, srq_enable, standard_event_latch, ev_read_data,
  input wire [7:0]        status_summary_byte,
  input wire [SRC_W-1:0]  alarm_bits, alarm_enable
);
  wire [7:0] sb = status_summary_byte;
  wire [7:0] sl = standard_event_latch;
  wire       qe = rd_empty_out || line_before_read || both_bufs_full;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_rsvd_zero: assert property (!sl[1] && !sl[6] && !sb[0]) else $error("reserved set");
  chk_opc_latch: assert property (opc_done |=> sl[0]) else $error("opc lost");
  chk_query_latch: assert property (qe |=> sl[2]) else $error("query lost");
  chk_exec_latch: assert property (err_valid && err_code <= -200 && err_code >= -299
    |=> sl[4]) else $error("exec lost");
  chk_read_clear: assert property (ev_read && !opc_done && !err_valid && !qe
    |=> sl == 8'h00 && ev_read_data == $past(sl)) else $error("read bad");
  chk_alarm_sum: assert property (sb[1] == |(alarm_bits & alarm_enable)) else $error("alarm");
  chk_mav_sum: assert property (sb[4] == out_pending) else $error("mav");
  chk_esb_sum: assert property (sb[5] == |(sl & ev_enable)) else $error("esb");
  chk_srq_sum: assert property (service_request == |(sb & srq_enable & 8'hbf)
    && sb[6] == service_request) else $error("srq");
endmodule
bind ses_core ses_props #(.SRC_W(SRC_W)) ses_props_i (.*);
`default_nettype wire

// File: verif/ses_host.sv
// Host model: issues read, clear and event strobes.
// Assumes the bench owns the clock.
`timescale 1ns/100ps
`default_nettype none
module ses_host (input wire logic clk, output logic [6:0] st);
  initial st = 7'h00;
  // One cycle wide, launched off the falling edge
  task automatic strobe(input logic [6:0] s);
    @(negedge clk) st = s;
    @(negedge clk) st = 7'h00;
  endtask
endmodule
`default_nettype wire

// File: verif/status_event_summary_test.sv
// Bench for the status event summary core.
// Assumes the host model drives strobes; bench drives levels and errors.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin comparisons++; if ((a)!==(b)) begin fail_count++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module status_event_summary_test;
  logic clk = 1'b0, rstn = 1'b0, err_valid = 1'b0, out_pending = 1'b0;
  logic signed [15:0] err_code = 16'h0000;
  logic [7:0] ev_enable = 8'h00, srq_enable = 8'h00;
  logic [15:0] ab = 16'h0000, qb = 16'h0000, ob = 16'h0000, en = 16'hffff;
  wire [7:0] evl, erd, sb;
  wire signed [15:0] ed;
  wire [6:0] st;
  wire srq, eqf;
  int fail_count = 0, comparisons = 0;
  ses_host ses_host_i (.clk(clk), .st(st));
  ses_core ses_core_i (.clk(clk), .rstn(rstn), .opc_done(st[0]), .rd_empty_out(st[1]),
    .line_before_read(st[2]), .both_bufs_full(st[3]), .ev_read(st[4]), .ev_clear(st[5]),
    .err_read(st[6]), .err_valid(err_valid), .err_code(err_code), .ev_enable(ev_enable),
    .srq_enable(srq_enable), .alarm_bits(ab), .alarm_enable(en), .ques_bits(qb),
    .ques_enable(en), .oper_bits(ob), .oper_enable(en), .out_pending(out_pending),
    .standard_event_latch(evl), .ev_read_data(erd), .status_summary_byte(sb),
    .service_request(srq), .err_read_data(ed), .err_queue_full(eqf));
  initial forever #10 clk = ~clk;
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_power;
    `CHK(evl, 8'h80)
    ses_host_i.strobe(7'h10);
    `CHK(erd, 8'h80)
    `CHK(evl, 8'h00)
    $display("t_power done");
  endtask
  task automatic t_events;
    for (int i = 0; i < 4; i++) begin
      ses_host_i.strobe(7'h01 << i);
      `CHK(evl, (i == 0) ? 8'h01 : 8'h04)
      ses_host_i.strobe(7'h20);
      `CHK(evl, 8'h00)
    end
    // Read and event in one cycle: the event survives
    ses_host_i.strobe(7'h11);
    `CHK(evl, 8'h01)
    $display("t_events done");
  endtask
  task automatic t_errors;
    logic signed [15:0] c[4] = '{-16'sd100, -16'sd250, -16'sd399, 16'sd5};
    logic [7:0] e[4] = '{8'h20, 8'h10, 8'h08, 8'h08};
    for (int i = 0; i < 4; i++) begin
      ses_host_i.strobe(7'h20);
      @(negedge clk) begin err_valid = 1'b1; err_code = c[i]; end
      @(negedge clk) err_valid = 1'b0;
      `CHK(evl, e[i])
    end
    `CHK(sb[2], 1'b1)
    for (int i = 0; i < 4; i++) begin
      ses_host_i.strobe(7'h40);
      `CHK(ed, c[i])
    end
    `CHK(sb[2], 1'b0)
    $display("t_errors done");
  endtask
  task automatic t_summary;
    logic [7:0] x[4] = '{8'h02, 8'h08, 8'h80, 8'h10};
    for (int i = 0; i < 4; i++) begin
      @(negedge clk) begin
        ab = {16{i == 0}}; qb = {16{i == 1}}; ob = {16{i == 2}};
        out_pending = (i == 3); srq_enable = x[i];
      end
      #1 `CHK(sb, x[i] | 8'h40)
    end
    @(negedge clk) begin ev_enable = 8'h08; srq_enable = 8'h00; out_pending = 1'b0; end
    #1 `CHK(sb, 8'h20)
    `CHK(srq, 1'b0)
    $display("t_summary done");
  endtask
  // Nine pushes into an eight-deep queue: the last is dropped
  task automatic t_full;
    for (int i = 0; i < 9; i++) begin
      @(negedge clk) begin err_valid = 1'b1; err_code = -16'sd150 - i; end
    end
    @(negedge clk) err_valid = 1'b0;
    `CHK(eqf, 1'b1)
    for (int i = 0; i < 9; i++) begin
      ses_host_i.strobe(7'h40);
      `CHK(ed, (i < 8) ? (-16'sd150 - i) : 16'sd0)
    end
    `CHK(eqf, 1'b0)
    `CHK(sb[2], 1'b0)
    $display("t_full done");
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    t_power;
    t_events;
    t_errors;
    t_summary;
    t_full;
    complete_run;
  end
endmodule
`default_nettype wire
